/* File: inc/acsm_pkg.sv */
// Constants for the converter status and mode register block
package acsm_pkg;

    // Register select codes carried in the command byte
    localparam logic [2:0]  RS_STATUS      = 3'h0;
    localparam logic [2:0]  RS_MODE        = 3'h1;
    localparam logic [2:0]  RS_CONFIG      = 3'h2;
    localparam logic [2:0]  RS_DATA        = 3'h3;
    localparam logic [2:0]  RS_IDENT       = 3'h4;
    localparam logic [2:0]  RS_GPO         = 3'h5;

    // Command byte fields
    localparam int          CMD_WEN        = 7;
    localparam int          CMD_READ       = 6;
    localparam int          CMD_RS_HI      = 5;
    localparam int          CMD_RS_LO      = 3;
    localparam logic [5:0]  CMD_LAST       = 6'h07;

    // Transfer lengths in bits
    localparam logic [5:0]  LEN_BYTE       = 6'h08;
    localparam logic [5:0]  LEN_WORD       = 6'h18;
    localparam logic [5:0]  LEN_WORD_STAT  = 6'h20;

    // Reset values and the mask of used mode bits
    localparam logic [23:0] MODE_RESET     = 24'h080060;
    localparam logic [7:0]  STATUS_RESET   = 8'h80;
    localparam logic [23:0] MODE_USED_MASK = 24'hfcafff;

    // Status field positions
    localparam int          ST_RDY         = 7;
    localparam int          ST_ERR         = 6;
    localparam int          ST_MISSING_REFERENCE_FLAG       = 5;
    localparam int          ST_PARITY      = 4;

    // Mode field positions
    localparam int          MD_OPMODE_HI   = 23;
    localparam int          MD_OPMODE_LO   = 21;
    localparam int          MD_APPEND      = 20;
    localparam int          MD_CLKSRC_HI   = 19;
    localparam int          MD_CLKSRC_LO   = 18;
    localparam int          MD_FILTER      = 15;
    localparam int          MD_PARITY      = 13;
    localparam int          MD_SINGLE      = 11;
    localparam int          MD_NOTCH60     = 10;
    localparam int          MD_RATE_HI     = 9;
    localparam int          MD_RATE_LO     = 0;

    // Operating modes
    localparam logic [2:0]  OPM_CONTINUOUS = 3'h0;
    localparam logic [2:0]  OPM_SINGLE     = 3'h1;
    localparam logic [2:0]  OPM_IDLE       = 3'h2;
    localparam logic [2:0]  OPM_POWERDOWN  = 3'h3;

    typedef enum logic [1:0] {LK_CMD, LK_WRITE, LK_READ} acsm_link_e;

endpackage : acsm_pkg

/* File: rtl/acsm_regs.sv */
// Status and mode registers with their serial link front end
//
// What this block does
// - New result clears the ready-pending flag
// - Data read or pre-update sets pending flag
// - Idle, power-down or sync low sets pending
// - Ready state also shown on output pin
// - Clamped result sets error, clears pending flag
// - Conversion-starting write clears error flag
// - Missing reference flagged, results forced ones
// - Reference flag only when detect enabled
// - Invalid reference also sets error flag
// - Parity bit follows data ones count
// - Append status after data on reads
// - Channel tag of stored result kept
// - Mode register 24 bits, MSB first
// - Mode select code 001, reset value
// - Mode write resets filter, sets pending
// - Mode fields at fixed bit positions
// - Status 8-bit read-only, code 000
`timescale 1ns/1ps
module acsm_regs (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Serial link
    input  wire logic        linkClk,
    input  wire logic        chipSelN,
    input  wire logic        serialIn,
    output logic             doutRdy,
    output logic             doutRdyOe,
    // Conversion core
    input  wire logic        convDone,
    input  wire logic [23:0] convData,
    input  wire logic [3:0]  convChannel,
    input  wire logic        convClamped,
    input  wire logic        convPreUpdate,
    input  wire logic        refBelowThreshold,
    input  wire logic        referenceDetectEnable,
    input  wire logic        filterSyncN,
    // Mode fields and results to the core
    output logic             modulatorReset,
    output logic [2:0]       operatingModeSelect,
    output logic             appendStatusEnable,
    output logic [1:0]       clockSourceSelect,
    output logic             filterOrderSelect,
    output logic             parityEnable,
    output logic             singleCycleEnable,
    output logic             notch60hzEnable,
    output logic [9:0]       rateDividerCode,
    output logic [23:0]      resultData,
    output logic [7:0]       conversionFlags
);
    import acsm_pkg::*;

    acsm_link_e  linkState_ff;
    acsm_link_e  nxt_linkState;
    logic [5:0]  bitCnt_ff;
    logic [5:0]  nxt_bitCnt;
    logic [23:0] rxShift_ff;
    logic [23:0] nxt_rxShift;
    logic [31:0] txShift_ff;
    logic [31:0] nxt_txShift;
    logic [2:0]  regSel_ff;
    logic [2:0]  nxt_regSel;
    logic [23:0] wrData_ff;
    logic [23:0] nxt_wrData;
    logic        wrTog_ff;
    logic        nxt_wrTog;
    logic        rdTog_ff;
    logic        nxt_rdTog;

    // Snapshots from the system domain; frozen while the frame is open
    logic [7:0]  shadowStatus_ff;
    logic [23:0] shadowMode_ff;
    logic [23:0] shadowData_ff;

    logic [7:0]  cmdByte;
    logic [2:0]  cmdSel;
    logic [5:0]  readLen;
    logic [31:0] readWord;

    always_comb begin
        cmdByte       = {rxShift_ff[6:0], serialIn};
        cmdSel        = cmdByte[CMD_RS_HI:CMD_RS_LO];
        nxt_linkState = linkState_ff;
        nxt_bitCnt    = bitCnt_ff;
        nxt_rxShift   = {rxShift_ff[22:0], serialIn};
        nxt_txShift   = txShift_ff;
        nxt_regSel    = regSel_ff;
        nxt_wrData    = wrData_ff;
        nxt_wrTog     = wrTog_ff;
        nxt_rdTog     = rdTog_ff;
        readLen       = LEN_WORD;
        readWord      = 32'h00000000;
        case (cmdSel)
            RS_STATUS: begin
                readLen  = LEN_BYTE;
                readWord = {shadowStatus_ff, 24'h000000};
            end
            RS_MODE: begin
                readWord = {shadowMode_ff, 8'h00};
            end
            RS_DATA: begin
                readLen  = shadowMode_ff[MD_APPEND] ? LEN_WORD_STAT : LEN_WORD;
                readWord = {shadowData_ff, shadowStatus_ff};
            end
            RS_IDENT, RS_GPO: begin
                readLen  = LEN_BYTE;
            end
            default: begin
                readLen  = LEN_WORD;
            end
        endcase
        case (linkState_ff)
            LK_CMD: begin
                // Leading one means no command yet; hold position
                if (bitCnt_ff == 6'h00 && serialIn) begin
                    nxt_bitCnt = 6'h00;
                end else if (bitCnt_ff == CMD_LAST) begin
                    nxt_bitCnt = 6'h00;
                    nxt_regSel = cmdSel;
                    if (cmdByte[CMD_READ]) begin
                        nxt_linkState = LK_READ;
                        nxt_bitCnt    = readLen;
                        nxt_txShift   = readWord;
                    end else if (cmdSel != RS_STATUS) begin
                        nxt_linkState = LK_WRITE;
                        nxt_bitCnt    = (cmdSel == RS_IDENT || cmdSel == RS_GPO) ?
                                        LEN_BYTE : LEN_WORD;
                    end
                end else begin
                    nxt_bitCnt = bitCnt_ff + 6'h01;
                end
            end
            LK_WRITE: begin
                nxt_bitCnt = bitCnt_ff - 6'h01;
                if (bitCnt_ff == 6'h01) begin
                    nxt_linkState = LK_CMD;
                    if (regSel_ff == RS_MODE) begin
                        nxt_wrData = nxt_rxShift;
                        nxt_wrTog  = ~wrTog_ff;
                    end
                end
            end
            LK_READ: begin
                nxt_bitCnt  = bitCnt_ff - 6'h01;
                nxt_txShift = {txShift_ff[30:0], 1'b0};
                if (bitCnt_ff == 6'h01) begin
                    nxt_linkState = LK_CMD;
                    if (regSel_ff == RS_DATA) begin
                        nxt_rdTog = ~rdTog_ff;
                    end
                end
            end
            default: begin
                nxt_linkState = LK_CMD;
                nxt_bitCnt    = 6'h00;
            end
        endcase
    end

    // Link clock stops between frames, so the frame select resets it
    always_ff @(posedge linkClk or posedge chipSelN) begin
        if (chipSelN) begin
            linkState_ff <= LK_CMD;
            bitCnt_ff    <= 6'h00;
            rxShift_ff   <= 24'h000000;
            txShift_ff   <= 32'h00000000;
            regSel_ff    <= 3'h0;
        end else begin
            linkState_ff <= nxt_linkState;
            bitCnt_ff    <= nxt_bitCnt;
            rxShift_ff   <= nxt_rxShift;
            txShift_ff   <= nxt_txShift;
            regSel_ff    <= nxt_regSel;
        end
    end
    // Toggles outlive the frame; rst starts them level with the seen copies
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            wrData_ff <= 24'h000000;
            {wrTog_ff, rdTog_ff} <= 2'b11;
        end else begin
            wrData_ff <= nxt_wrData;
            wrTog_ff  <= nxt_wrTog;
            rdTog_ff  <= nxt_rdTog;
        end
    end

    logic [1:0]  togSync;
    logic        frameIdleS;
    logic        syncLowS;
    logic        wrTogSeen_ff;
    logic        rdTogSeen_ff;
    logic [23:0] mode_ff;
    logic [23:0] nxt_mode;
    logic [23:0] data_ff;
    logic [23:0] nxt_data;
    logic [3:0]  chan_ff;
    logic [3:0]  nxt_chan;
    logic        rdyN_ff;
    logic        nxt_rdyN;
    logic        err_ff;
    logic        nxt_err;
    logic        modReset_ff;
    logic        nxt_modReset;
    logic [7:0]  nxt_shadowStatus;
    logic [23:0] nxt_shadowMode;
    logic [23:0] nxt_shadowData;
    logic        wrEvent;
    logic        rdEvent;
    logic        missingRef;
    logic        parityBit;
    logic        startsConv;
    logic [2:0]  opMode;

    acsm_sync #(.WIDTH(4)) u_sync (
        .clk      (sys_clk),
        .rst      (rst),
        .asyncIn  ({wrTog_ff, rdTog_ff, chipSelN, filterSyncN}),
        .resetVal (4'hf),
        .syncOut  ({togSync, frameIdleS, syncLowS})
    );

    always_comb begin
        wrEvent    = togSync[1] ^ wrTogSeen_ff;
        rdEvent    = togSync[0] ^ rdTogSeen_ff;
        opMode     = mode_ff[MD_OPMODE_HI:MD_OPMODE_LO];
        missingRef = referenceDetectEnable & refBelowThreshold;
        parityBit  = mode_ff[MD_PARITY] & (^data_ff);
        startsConv = (wrData_ff[MD_OPMODE_HI:MD_OPMODE_LO] == OPM_CONTINUOUS) ||
                     (wrData_ff[MD_OPMODE_HI:MD_OPMODE_LO] == OPM_SINGLE);

        nxt_mode     = mode_ff;
        nxt_modReset = 1'b0;
        nxt_data     = data_ff;
        nxt_chan     = chan_ff;
        nxt_rdyN     = rdyN_ff;
        nxt_err      = err_ff;

        if (wrEvent && startsConv) begin
            nxt_err = 1'b0;
        end
        if (wrEvent) begin
            nxt_mode     = wrData_ff & MODE_USED_MASK;
            nxt_modReset = 1'b1;
        end
        if (convDone) begin
            nxt_data = missingRef ? 24'hffffff : convData;
            nxt_chan = convChannel;
            nxt_rdyN = 1'b0;
            if (convClamped || missingRef) begin
                nxt_err = 1'b1;
            end
        end
        if (missingRef) begin
            nxt_err = 1'b1;
        end
        // Sets come last so a set in the clearing cycle wins
        // read or pre-update
        if (rdEvent || convPreUpdate) begin
            nxt_rdyN = 1'b1;
        end
        if (opMode == OPM_IDLE || opMode == OPM_POWERDOWN || !syncLowS) begin
            nxt_rdyN = 1'b1;
        end
        if (wrEvent) begin
            nxt_rdyN = 1'b1;
        end

        nxt_shadowStatus = shadowStatus_ff;
        nxt_shadowMode   = shadowMode_ff;
        nxt_shadowData   = shadowData_ff;
        // Snapshots only move while no frame is open
        if (frameIdleS) begin
            nxt_shadowStatus = conversionFlags;
            nxt_shadowMode   = mode_ff;
            nxt_shadowData   = data_ff;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_ff         <= MODE_RESET;
            data_ff         <= 24'h000000;
            chan_ff         <= STATUS_RESET[3:0];
            rdyN_ff         <= STATUS_RESET[ST_RDY];
            err_ff          <= STATUS_RESET[ST_ERR];
            modReset_ff     <= 1'b0;
            wrTogSeen_ff    <= 1'b1;
            rdTogSeen_ff    <= 1'b1;
            shadowStatus_ff <= STATUS_RESET;
            shadowMode_ff   <= MODE_RESET;
            shadowData_ff   <= 24'h000000;
        end else begin
            mode_ff         <= nxt_mode;
            data_ff         <= nxt_data;
            chan_ff         <= nxt_chan;
            rdyN_ff         <= nxt_rdyN;
            err_ff          <= nxt_err;
            modReset_ff     <= nxt_modReset;
            wrTogSeen_ff    <= togSync[1];
            rdTogSeen_ff    <= togSync[0];
            shadowStatus_ff <= nxt_shadowStatus;
            shadowMode_ff   <= nxt_shadowMode;
            shadowData_ff   <= nxt_shadowData;
        end
    end

    assign conversionFlags     = {rdyN_ff, err_ff, missingRef, parityBit, chan_ff};
    // ready shown on pin outside reads
    assign doutRdy             = (linkState_ff == LK_READ) ? txShift_ff[31] : rdyN_ff;
    assign doutRdyOe           = ~chipSelN;
    assign operatingModeSelect = mode_ff[MD_OPMODE_HI:MD_OPMODE_LO];
    assign appendStatusEnable  = mode_ff[MD_APPEND];
    assign clockSourceSelect   = mode_ff[MD_CLKSRC_HI:MD_CLKSRC_LO];
    assign filterOrderSelect   = mode_ff[MD_FILTER];
    assign parityEnable        = mode_ff[MD_PARITY];
    assign singleCycleEnable   = mode_ff[MD_SINGLE];
    assign notch60hzEnable     = mode_ff[MD_NOTCH60];
    assign rateDividerCode     = mode_ff[MD_RATE_HI:MD_RATE_LO];
    assign modulatorReset      = modReset_ff;
    assign resultData          = data_ff;

endmodule : acsm_regs

/* File: rtl/acsm_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps
module acsm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    input  wire logic [WIDTH-1:0] resetVal,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] nxt_stage1;
    logic [WIDTH-1:0] nxt_stage2;

    always_comb begin
        nxt_stage1 = rst ? resetVal : asyncIn;
        nxt_stage2 = rst ? resetVal : stage1_ff;
    end

    always_ff @(posedge clk) begin
        stage1_ff <= nxt_stage1;
        stage2_ff <= nxt_stage2;
    end

    assign syncOut = stage2_ff;
endmodule : acsm_sync

/* File: tb/acsm_host_model.sv */
// Host side serial master for the converter link
`timescale 1ns/1ps
module acsm_host_model
    import acsm_pkg::*;
(
    output logic      linkClk,
    output logic      chipSelN,
    output logic      serialIn,
    input  wire logic doutRdy
);
    initial begin
        linkClk  = 1'b1;
        chipSelN = 1'b0;
        serialIn = 1'b1;
        // One clean rising select edge puts the link state at rest
        #1 chipSelN = 1'b1;
    end

    // Clock runs only inside a frame; odd offset keeps phase apart
    task automatic xfer(input logic [7:0] cmd, input logic [31:0] wdat,
                        input int n, output logic [31:0] rdat);
        logic [39:0] sh;
        // unused mode bits sent as zero
        if (cmd[5:3] == RS_MODE && !cmd[6])
            wdat &= {8'h00, MODE_USED_MASK};
        sh = {cmd, wdat << (32 - n)};
        rdat = 32'h0;
        chipSelN = 1'b0;
        #21.3;
        for (int i = 0; i < 8 + n; i++) begin
            linkClk = 1'b0;
            if (i >= 8)
                rdat = {rdat[30:0], doutRdy};
            serialIn = sh[39 - i];
            #7.5;
            linkClk = 1'b1;
            #7.5;
        end
        chipSelN = 1'b1;
        serialIn = ~serialIn;
        #20;
    endtask : xfer
endmodule : acsm_host_model

/* File: tb/acsm_regs_sva.sv */
// Assertion checker for the status and mode registers
`timescale 1ns/1ps
module acsm_regs_sva (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        chipSelN,
    input wire logic        doutRdy,
    input wire logic        doutRdyOe,
    input wire logic        convDone,
    input wire logic [3:0]  convChannel,
    input wire logic        convClamped,
    input wire logic        convPreUpdate,
    input wire logic        refBelowThreshold,
    input wire logic        referenceDetectEnable,
    input wire logic        filterSyncN,
    input wire logic        modulatorReset,
    input wire logic [2:0]  operatingModeSelect,
    input wire logic        parityEnable,
    input wire logic [23:0] resultData,
    input wire logic [7:0]  conversionFlags
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_rdyClr;
        convDone && !convPreUpdate && operatingModeSelect < 3'h2 && filterSyncN
            |=> !conversionFlags[7];
    endproperty
    a_rdyClr: assert property (p_rdyClr)
        else $error("pending flag not cleared");
    property p_chan;
        convDone |=> conversionFlags[3:0] == $past(convChannel);
    endproperty
    a_chan: assert property (p_chan)
        else $error("channel tag wrong");
    property p_clamp;
        convDone && convClamped |=> conversionFlags[6];
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("clamp error flag missing");
    property p_forceOnes;
        convDone && referenceDetectEnable && refBelowThreshold |=> resultData == 24'hffffff;
    endproperty
    a_forceOnes: assert property (p_forceOnes)
        else $error("result not forced to ones");
    property p_refFlag;
        conversionFlags[5] == (referenceDetectEnable && refBelowThreshold);
    endproperty
    a_refFlag: assert property (p_refFlag)
        else $error("reference flag wrong");
    property p_refErr;
        referenceDetectEnable && refBelowThreshold |=> conversionFlags[6];
    endproperty
    a_refErr: assert property (p_refErr)
        else $error("error flag not held");
    property p_parity;
        conversionFlags[4] == (parityEnable && ^resultData);
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity bit wrong");
    property p_idle;
        operatingModeSelect >= 3'h2 |=> conversionFlags[7];
    endproperty
    a_idle: assert property (p_idle)
        else $error("pending flag not forced");
    property p_modRst;
        modulatorReset |-> ##[0:1] conversionFlags[7] ##1 !modulatorReset;
    endproperty
    a_modRst: assert property (p_modRst)
        else $error("mode write side effect wrong");
    property p_pin;
        chipSelN |-> doutRdy == conversionFlags[7] && !doutRdyOe;
    endproperty
    a_pin: assert property (p_pin)
        else $error("ready pin wrong");

    c_conv: cover property (convDone ##1 !conversionFlags[7]);
    c_modRst: cover property (modulatorReset);
    c_missing_reference_flag: cover property (convDone && referenceDetectEnable && refBelowThreshold);
endmodule : acsm_regs_sva

bind acsm_regs acsm_regs_sva u_sva (
    .sys_clk(sys_clk), .rst(rst), .chipSelN(chipSelN), .doutRdy(doutRdy),
    .doutRdyOe(doutRdyOe), .convDone(convDone), .convChannel(convChannel),
    .convClamped(convClamped), .convPreUpdate(convPreUpdate),
    .refBelowThreshold(refBelowThreshold), .referenceDetectEnable(referenceDetectEnable),
    .filterSyncN(filterSyncN), .modulatorReset(modulatorReset),
    .operatingModeSelect(operatingModeSelect), .parityEnable(parityEnable),
    .resultData(resultData), .conversionFlags(conversionFlags));

/* File: tb/test_acsm_regs.sv */
// Self-checking bench for the status and mode registers
`timescale 1ns/1ps
module test_acsm_regs;
    typedef struct {
        logic [23:0] d;
        logic [3:0]  c;
        logic        cl;
        logic        rl;
        logic [23:0] ed;
        logic [7:0]  ef;
    } acsm_row_s;

    logic sys_clk = 1'b0, rst = 1'b0, linkClk, chipSelN, serialIn, doutRdy, doutRdyOe;
    logic convDone = 1'b0, convClamped = 1'b0, convPreUpdate = 1'b0;
    logic refBelowThreshold = 1'b0, referenceDetectEnable = 1'b1, filterSyncN = 1'b1;
    logic [23:0] convData = 24'h0;
    logic [3:0]  convChannel = 4'h0;
    logic modulatorReset, appendStatusEnable, filterOrderSelect, parityEnable;
    logic singleCycleEnable, notch60hzEnable;
    logic [2:0]  operatingModeSelect;
    logic [1:0]  clockSourceSelect;
    logic [9:0]  rateDividerCode;
    logic [23:0] resultData;
    logic [7:0]  conversionFlags;
    logic [31:0] rd;
    int          miscompares = 0;
    int          comparisons = 0;
    acsm_row_s   rows [4];
    wire  [23:0] modeOut = {operatingModeSelect, appendStatusEnable, clockSourceSelect,
        2'b00, filterOrderSelect, 1'b0, parityEnable, 1'b0, singleCycleEnable,
        notch60hzEnable, rateDividerCode};

    always #2.5 sys_clk = ~sys_clk;

    acsm_host_model host (.linkClk(linkClk), .chipSelN(chipSelN), .serialIn(serialIn),
        .doutRdy(doutRdy));
    acsm_regs dut (.sys_clk(sys_clk), .rst(rst), .linkClk(linkClk), .chipSelN(chipSelN),
        .serialIn(serialIn), .doutRdy(doutRdy), .doutRdyOe(doutRdyOe),
        .convDone(convDone), .convData(convData), .convChannel(convChannel),
        .convClamped(convClamped), .convPreUpdate(convPreUpdate),
        .refBelowThreshold(refBelowThreshold),
        .referenceDetectEnable(referenceDetectEnable), .filterSyncN(filterSyncN),
        .modulatorReset(modulatorReset), .operatingModeSelect(operatingModeSelect),
        .appendStatusEnable(appendStatusEnable), .clockSourceSelect(clockSourceSelect),
        .filterOrderSelect(filterOrderSelect), .parityEnable(parityEnable),
        .singleCycleEnable(singleCycleEnable), .notch60hzEnable(notch60hzEnable),
        .rateDividerCode(rateDividerCode), .resultData(resultData),
        .conversionFlags(conversionFlags));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize;
        $display("checks=%0d errors=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    // Returns at the falling edge after the capture edge
    task automatic conv(input logic [23:0] d, input logic [3:0] c, input logic cl);
        @(negedge sys_clk);
        convDone = 1'b1;
        convData = d;
        convChannel = c;
        convClamped = cl;
        @(negedge sys_clk);
        convDone = 1'b0;
        convClamped = 1'b0;
    endtask : conv

    // Mode write, then let the update cross into the system domain
    task automatic wrMode(input logic [23:0] v);
        host.xfer(8'h08, {8'h00, v}, 24, rd);
        repeat (8) @(negedge sys_clk);
    endtask : wrMode

    initial begin
        #100000;
        miscompares++;
        summarize();
    end

    initial begin
        // Sticky error flag: clean rows first
        rows[0] = '{24'h000003, 4'h1, 1'b0, 1'b0, 24'h000003, 8'h01};
        rows[1] = '{24'h800000, 4'h2, 1'b0, 1'b0, 24'h800000, 8'h12};
        rows[2] = '{24'hffffff, 4'h3, 1'b1, 1'b0, 24'hffffff, 8'h43};
        rows[3] = '{24'h123456, 4'hf, 1'b0, 1'b1, 24'hffffff, 8'h6f};
        // Rising reset edge also sets the link-side toggles to one
        #1 rst = 1'b1;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        repeat (5) @(negedge sys_clk);
        chk(conversionFlags, 8'h80);
        chk(modeOut, 24'h080060);
        host.xfer(8'h48, 32'h0, 24, rd);
        chk(rd, 32'h080060);
        host.xfer(8'h40, 32'h0, 8, rd);
        chk(rd, 32'h80);
        wrMode(24'h14a7ff);
        chk(modeOut, 24'h14a7ff);
        for (int i = 0; i < 4; i++) begin
            refBelowThreshold = rows[i].rl;
            conv(rows[i].d, rows[i].c, rows[i].cl);
            chk(resultData, rows[i].ed);
            chk(conversionFlags, rows[i].ef);
            chk(doutRdy, 1'b0);
        end
        refBelowThreshold = 1'b0;
        @(negedge sys_clk);
        host.xfer(8'h58, 32'h0, 32, rd);
        chk(rd, 32'hffffff4f);
        repeat (6) @(negedge sys_clk);
        chk(conversionFlags[7], 1'b1);
        wrMode(24'h34a7ff);
        chk(conversionFlags, 8'h8f);
        host.xfer(8'h48, 32'h0, 24, rd);
        chk(rd, 32'h34a7ff);
        host.xfer(8'h40, 32'h0, 8, rd);
        chk(rd, 32'h8f);
        conv(24'h000001, 4'h5, 1'b0);
        convPreUpdate = 1'b1;
        @(negedge sys_clk);
        convPreUpdate = 1'b0;
        @(negedge sys_clk);
        chk(conversionFlags[7], 1'b1);
        conv(24'h000001, 4'h5, 1'b0);
        filterSyncN = 1'b0;
        repeat (5) @(negedge sys_clk);
        chk(conversionFlags[7], 1'b1);
        filterSyncN = 1'b1;
        repeat (5) @(negedge sys_clk);
        wrMode(24'h54a7ff);
        conv(24'h000002, 4'h6, 1'b0);
        chk(conversionFlags, 8'h96);
        summarize();
    end
endmodule : test_acsm_regs
